// file: common/wbc_pkg.sv
package wbc_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_MEDIA} phase_type;

  typedef struct packed {
    logic [7:0]  op;
    logic [3:0]  mode;
    logic [7:0]  sel;
    logic [23:0] off;
    logic [23:0] len;
    logic        disable_page_out_bit;
    logic        force_media_write_bit;
    logic        rel;
  } cmd_type;

  // Register byte offsets
  localparam logic [4:0] REG_CDB0   = 5'h00;
  localparam logic [4:0] REG_CDB1   = 5'h04;
  localparam logic [4:0] REG_CDB2   = 5'h08;
  localparam logic [4:0] REG_CTRL   = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_DATA   = 5'h14;
  localparam logic [4:0] REG_DLSIZE = 5'h18;

  // Control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_WHO   = 1;
  localparam int CTRL_RIDX  = 8;

  // Command codes and modes
  localparam logic [7:0] OP_WRBUF = 8'h3b;
  localparam logic [7:0] OP_WREXT = 8'h2a;
  localparam logic [3:0] MODE_DATA = 4'h2;
  localparam logic [3:0] MODE_DL   = 4'h4;
  localparam logic [3:0] MODE_SAVE = 4'h5;
  localparam logic [3:0] MODE_ECHO = 4'ha;
  localparam logic [7:0] SEL_MAIN  = 8'h00;
  localparam logic [7:0] SEL_RSVD  = 8'h81;

  // Status and sense
  localparam logic [7:0] STAT_GOOD  = 8'h00;
  localparam logic [7:0] STAT_CHECK = 8'h02;
  localparam logic [3:0] KEY_NONE   = 4'h0;
  localparam logic [3:0] KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE   = 8'h00;
  localparam logic [7:0] ASC_BAD_OP = 8'h20;
  localparam logic [7:0] ASC_FIELD  = 8'h24;
  localparam logic [7:0] ASC_CODE   = 8'h26;

  localparam logic [23:0] CHUNK_BYTES = 24'h008000;
  localparam int          SAVE_TIME_S = 30;
  localparam logic [23:0] DLSIZE_RST  = 24'h000000;
endpackage : wbc_pkg

// file: rtl/wbc_checker.sv
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module wbc_checker #(
  parameter int BUF_BYTES   = 64,
  parameter int SECT_BYTES  = 16,
  parameter int BLOCK_BYTES = 512
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Device status
  input  wire logic        full_op_i,
  input  wire logic        code_ok_i,
  input  wire logic        media_done_i,
  // Device actions
  output logic      [7:0]  xfer_byte_o,
  output logic             xfer_valid_o,
  output logic             code_run_o,
  output logic             self_reset_o,
  output logic             ua_set_o,
  output logic      [7:0]  ua_mask_o,
  output logic             seek_o,
  output logic             cache_low_prio_o,
  output logic             media_flush_o
);
  localparam int WORDS = BUF_BYTES / 4;
  localparam int IW    = $clog2(WORDS);

  typedef struct packed {
    wbc_pkg::phase_type      ph;
    logic                    ack;
    logic [31:0]             rdata;
    logic [2:0][31:0]        cdb;
    logic [2:0]              who;
    logic [IW-1:0]           ridx;
    logic [23:0]             dl_size;
    wbc_pkg::cmd_type        cmd;
    logic [7:0]              status;
    logic [3:0]              skey;
    logic [7:0]              asc;
    logic                    done;
    logic [31:0]             cnt;
    logic [31:0]             need;
    logic [23:0]             acc;
    logic                    run;
    logic                    save;
    logic                    ua;
    logic                    seek;
    logic                    xv;
    logic [7:0]              xb;
    logic [WORDS-1:0][31:0]  mem;
  } st_type;

  st_type           q;
  st_type           n;
  wbc_pkg::cmd_type dc;
  logic [7:0]       b [10];
  logic             bad;
  logic [7:0]       bad_asc;
  logic [31:0]      dc_need;
  logic [31:0]      ptr;
  logic [24:0]      acc_sum;
  logic             start;
  logic             wr_take;
  logic             fin;

  always_comb
  begin
    for (int i = 0; i < 10; i++)
    begin
      b[i] = q.cdb[i/4][8*(i%4) +: 8];
    end
  end

  // Command block decode and checks, done before any data is taken
  always_comb
  begin
    dc      = '0;
    dc.op   = b[0];
    dc.rel  = b[1][0];
    bad     = 1'b0;
    bad_asc = wbc_pkg::ASC_FIELD;
    dc_need = '0;
    acc_sum = {1'b0, q.acc} + {1'b0, dc.len};
    if (b[0] == wbc_pkg::OP_WRBUF)
    begin
      dc.mode = b[1][3:0];
      dc.sel  = b[2];
      dc.off  = {b[3], b[4], b[5]};
      dc.len  = {b[6], b[7], b[8]};
      acc_sum = {1'b0, q.acc} + {1'b0, dc.len};
      dc_need = {8'h00, dc.len};
      unique case (dc.mode)
        wbc_pkg::MODE_DATA:
        begin
          bad = (dc.sel != wbc_pkg::SEL_MAIN)
              | ({8'h00, dc.off} >= 32'(BUF_BYTES))
              | ({8'h00, dc.off} + {8'h00, dc.len}
                 > 32'(BUF_BYTES))
              | ({8'h00, dc.len} >= 32'(BUF_BYTES))
              | ({8'h00, dc.len} % 32'(SECT_BYTES) != 32'h0);
        end
        wbc_pkg::MODE_DL:
        begin
          bad = ((dc.sel != wbc_pkg::SEL_MAIN)
                 && (dc.sel != wbc_pkg::SEL_RSVD))
              | (dc.off != 24'h0)
              | ((dc.len != 24'h0)
                 && (dc.len != q.dl_size));
        end
        wbc_pkg::MODE_SAVE:
        begin
          // Chunk sizes are checked against the running total
          bad = (dc.sel != wbc_pkg::SEL_MAIN)
              | ~full_op_i
              | (dc.off != 24'h0)
              | (dc.len == 24'h0)
              | (acc_sum > {1'b0, q.dl_size})
              | ((dc.len != q.dl_size)
                 && (dc.len != wbc_pkg::CHUNK_BYTES)
                 && (acc_sum != {1'b0, q.dl_size}));
        end
        wbc_pkg::MODE_ECHO:
        begin
          bad = ({8'h00, dc.len} > 32'(BUF_BYTES));
        end
        default:
        begin
          bad = 1'b1;
        end
      endcase
    end
    else if (b[0] == wbc_pkg::OP_WREXT)
    begin
      dc.disable_page_out_bit  = b[1][4];
      dc.force_media_write_bit  = b[1][3];
      dc.len  = {8'h00, b[7], b[8]};
      dc_need = 32'({b[7], b[8]} * 25'(BLOCK_BYTES));
      bad     = dc.rel;
    end
    else
    begin
      bad     = 1'b1;
      bad_asc = wbc_pkg::ASC_BAD_OP;
    end
  end

  assign start   = avs_write_i & q.ack & (avs_address_i == wbc_pkg::REG_CTRL)
                 & avs_writedata_i[wbc_pkg::CTRL_START]
                 & (q.ph == wbc_pkg::PH_IDLE);
  assign wr_take = avs_write_i & q.ack & (avs_address_i == wbc_pkg::REG_DATA)
                 & (q.ph == wbc_pkg::PH_DATA);
  assign ptr     = (q.cmd.mode == wbc_pkg::MODE_DATA)
                 ? ({8'h00, q.cmd.off} + q.cnt) : q.cnt;

  always_comb
  begin
    n      = q;
    n.run  = 1'b0;
    n.save = 1'b0;
    n.ua   = 1'b0;
    n.seek = 1'b0;
    n.xv   = 1'b0;
    fin    = 1'b0;
    // One wait state per access: answer on the second cycle
    n.ack  = (avs_read_i | avs_write_i) & ~q.ack;
    if (avs_read_i & ~q.ack)
    begin
      unique case (avs_address_i)
        wbc_pkg::REG_CDB0:   n.rdata = q.cdb[0];
        wbc_pkg::REG_CDB1:   n.rdata = q.cdb[1];
        wbc_pkg::REG_CDB2:   n.rdata = {16'h0000, q.cdb[2][15:0]};
        wbc_pkg::REG_CTRL:   n.rdata = 32'({q.ridx, 4'h0, q.who, 1'b0});
        wbc_pkg::REG_STATUS: n.rdata = {6'h00, q.ph, q.asc, 3'h0, q.done,
                                        q.skey, q.status};
        wbc_pkg::REG_DATA:   n.rdata = q.mem[q.ridx];
        wbc_pkg::REG_DLSIZE: n.rdata = {8'h00, q.dl_size};
        default:             n.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i & q.ack)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (avs_byteenable_i[i])
        begin
          if (avs_address_i == wbc_pkg::REG_CDB0)
            n.cdb[0][8*i +: 8] = avs_writedata_i[8*i +: 8];
          if (avs_address_i == wbc_pkg::REG_CDB1)
            n.cdb[1][8*i +: 8] = avs_writedata_i[8*i +: 8];
          if ((avs_address_i == wbc_pkg::REG_CDB2) && (i < 2))
            n.cdb[2][8*i +: 8] = avs_writedata_i[8*i +: 8];
        end
      end
      if (avs_address_i == wbc_pkg::REG_CTRL)
      begin
        n.who  = avs_writedata_i[wbc_pkg::CTRL_WHO +: 3];
        n.ridx = avs_writedata_i[wbc_pkg::CTRL_RIDX +: IW];
      end
      if ((avs_address_i == wbc_pkg::REG_DLSIZE)
          && (q.ph == wbc_pkg::PH_IDLE))
        n.dl_size = avs_writedata_i[23:0];
    end
    if (start)
    begin
      n.done = 1'b0;
      n.cmd  = dc;
      n.cnt  = '0;
      n.need = dc_need;
      if (bad)
      begin
        // Nothing goes to the buffer on a rejected command; the command and its check status are still latched
        n.status = wbc_pkg::STAT_CHECK;
        n.skey   = wbc_pkg::KEY_ILLEGAL;
        n.asc    = bad_asc;
        n.done   = 1'b1;
      end
      else
      begin
        n.seek = (dc.op == wbc_pkg::OP_WREXT);
        if (dc_need == 32'h0)
          fin = 1'b1;
        else
          n.ph = wbc_pkg::PH_DATA;
      end
    end
    // Buffer words change only on data and echo mode writes, so echo data stays put
    if (wr_take)
    begin
      if ((q.cmd.op == wbc_pkg::OP_WRBUF)
          && ((q.cmd.mode == wbc_pkg::MODE_DATA)
              || (q.cmd.mode == wbc_pkg::MODE_ECHO)))
        n.mem[ptr[IW+1:2]][8*ptr[1:0] +: 8] = avs_writedata_i[7:0];
      else
      begin
        n.xb = avs_writedata_i[7:0];
        n.xv = 1'b1;
      end
      n.cnt = q.cnt + 32'h1;
      fin   = (n.cnt == q.need);
    end
    if (fin)
    begin
      n.ph     = wbc_pkg::PH_IDLE;
      n.status = wbc_pkg::STAT_GOOD;
      n.skey   = wbc_pkg::KEY_NONE;
      n.asc    = wbc_pkg::ASC_NONE;
      n.done   = 1'b1;
      if (n.cmd.op == wbc_pkg::OP_WREXT)
      begin
        if (n.cmd.force_media_write_bit && (n.need != 32'h0))
        begin
          n.ph   = wbc_pkg::PH_MEDIA;
          n.done = 1'b0;
        end
      end
      else if ((n.cmd.mode == wbc_pkg::MODE_DL) && (n.need != 32'h0))
      begin
        if (code_ok_i)
        begin
          n.run = 1'b1;
          n.ua  = 1'b1;
        end
        else
        begin
          n.status = wbc_pkg::STAT_CHECK;
          n.skey   = wbc_pkg::KEY_ILLEGAL;
          n.asc    = wbc_pkg::ASC_CODE;
        end
      end
      else if (n.cmd.mode == wbc_pkg::MODE_SAVE)
      begin
        n.acc = q.acc + n.cmd.len;
        if (!code_ok_i)
        begin
          n.acc    = '0;
          n.status = wbc_pkg::STAT_CHECK;
          n.skey   = wbc_pkg::KEY_ILLEGAL;
          n.asc    = wbc_pkg::ASC_CODE;
        end
        else if (n.acc == q.dl_size)
        begin
          n.acc  = '0;
          n.save = 1'b1;
        end
      end
    end
    if ((q.ph == wbc_pkg::PH_MEDIA) && media_done_i)
    begin
      n.ph     = wbc_pkg::PH_IDLE;
      n.status = wbc_pkg::STAT_GOOD;
      n.done   = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      q <= '0;
    else
      q <= n;
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
  assign avs_readdata_o    = q.rdata;
  assign xfer_byte_o       = q.xb;
  assign xfer_valid_o      = q.xv;
  assign code_run_o        = q.run;
  assign self_reset_o      = q.save;
  assign ua_set_o          = q.ua;
  assign ua_mask_o         = ~(8'h01 << q.who);
  assign seek_o            = q.seek;
  // Held for the whole extended write so the cache sees it per block
  assign cache_low_prio_o  = q.cmd.disable_page_out_bit & (q.cmd.op == wbc_pkg::OP_WREXT)
                           & (q.ph != wbc_pkg::PH_IDLE);
  assign media_flush_o     = (q.ph == wbc_pkg::PH_MEDIA);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_start_wb(logic [3:0] m);
    start && (dc.op == wbc_pkg::OP_WRBUF) && (dc.mode == m);
  endsequence
  sequence s_checked;
    q.status == wbc_pkg::STAT_CHECK && q.skey == wbc_pkg::KEY_ILLEGAL
      && q.asc == wbc_pkg::ASC_FIELD && q.done;
  endsequence

  chk_data_sel: assert property (
    s_start_wb(wbc_pkg::MODE_DATA) ##0 (dc.sel != 8'h00) |=> s_checked)
    else $error("data mode select not rejected");
  chk_data_off: assert property (
    s_start_wb(wbc_pkg::MODE_DATA) ##0 ({8'h00, dc.off} >= BUF_BYTES)
      |=> s_checked)
    else $error("data offset not rejected");
  chk_data_len: assert property (
    s_start_wb(wbc_pkg::MODE_DATA) ##0 (dc.len % SECT_BYTES != 0)
      |=> s_checked)
    else $error("data length not rejected");
  chk_dl_sel: assert property (
    s_start_wb(wbc_pkg::MODE_DL) ##0 (dc.sel != 8'h00)
      ##0 (dc.sel != 8'h81) |=> s_checked)
    else $error("download select not rejected");
  chk_dl_off: assert property (
    s_start_wb(wbc_pkg::MODE_DL) ##0 (dc.off != 0) |=> s_checked)
    else $error("download offset not rejected");
  chk_ua_mask: assert property (
    ua_set_o |-> code_run_o && !ua_mask_o[q.who])
    else $error("unit attention reaches issuer");
  chk_save_sel: assert property (
    s_start_wb(wbc_pkg::MODE_SAVE) ##0 (dc.sel != 8'h00) |=> s_checked)
    else $error("save select not rejected");
  chk_seek_zero: assert property (
    start && dc.op == wbc_pkg::OP_WREXT && !bad && dc.len == 0
      |=> seek_o && q.status == wbc_pkg::STAT_GOOD && q.done)
    else $error("zero length extended write wrong");
  chk_fua_hold: assert property (
    media_flush_o && !media_done_i |=> !q.done && media_flush_o)
    else $error("good status before media commit");
  chk_reject_keep: assert property (
    start && bad |=> $stable(q.mem) && q.ph == wbc_pkg::PH_IDLE)
    else $error("rejected command touched buffer");
endmodule : wbc_checker

// file: verification/media_model.sv
`timescale 1ns/1ps
module media_model #(
  parameter int DELAY = 12
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // Commit request and answer
  input  wire logic flush_i,
  output logic      done_o
);
  logic [7:0] cnt_q;

  // A slow medium: commit ends DELAY+1 cycles after the request
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q  <= 8'h00;
      done_o <= 1'b0;
    end
    else
    begin
      cnt_q  <= flush_i ? cnt_q + 8'h01 : 8'h00;
      done_o <= flush_i && (cnt_q == 8'(DELAY));
    end
  end
endmodule : media_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        mclk_i;
  logic        rst_b_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        full_op_i;
  logic        code_ok_i;
  logic        media_done_i;
  logic [7:0]  xfer_byte_o;
  logic        xfer_valid_o;
  logic        code_run_o;
  logic        self_reset_o;
  logic        ua_set_o;
  logic [7:0]  ua_mask_o;
  logic        seek_o;
  logic        cache_low_prio_o;
  logic        media_flush_o;
  logic [31:0] rd;
  int          errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n_x, n_run, n_rst, n_ua, n_seek;

  // Short blocks keep the extended write cheap to simulate
  wbc_checker #(.BLOCK_BYTES(4)) wbc_checker_inst (
    .mclk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
    .avs_waitrequest_o, .full_op_i, .code_ok_i, .media_done_i,
    .xfer_byte_o, .xfer_valid_o, .code_run_o, .self_reset_o, .ua_set_o,
    .ua_mask_o, .seek_o, .cache_low_prio_o, .media_flush_o);

  media_model media_model_inst (
    .mclk_i, .rst_b_i, .flush_i(media_flush_o), .done_o(media_done_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    cycles++;
    n_x    += int'(xfer_valid_o === 1'b1);
    n_run  += int'(code_run_o === 1'b1);
    n_rst  += int'(self_reset_o === 1'b1);
    n_ua   += int'(ua_set_o === 1'b1);
    n_seek += int'(seek_o === 1'b1);
    if (cycles == 6000)
    begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
    end
  end

  task complete_run;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk

  // Request held until the edge that sees waitrequest low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= d;
    @(posedge mclk_i);
    // Only waitrequest low or the bench timeout ends this wait
    while (avs_waitrequest_o !== 1'b0)
      @(posedge mclk_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    // Idle edge so the next call never re-drives the strobe in this step
    @(posedge mclk_i);
  endtask : bus

  task cmd(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
           input logic [23:0] off, input logic [23:0] len,
           input logic [2:0] who);
    n_x = 0;
    n_run = 0;
    n_rst = 0;
    n_ua = 0;
    n_seek = 0;
    bus(1'b1, wbc_pkg::REG_CDB0, {off[23:16], b2, b1, op});
    bus(1'b1, wbc_pkg::REG_CDB1, {len[15:8], len[23:16], off[7:0], off[15:8]});
    bus(1'b1, wbc_pkg::REG_CDB2, {24'h000000, len[7:0]});
    bus(1'b1, wbc_pkg::REG_CTRL, {28'h0000000, who, 1'b1});
  endtask : cmd

  task sts(input logic [7:0] st, input logic [3:0] key, input logic [7:0] asc);
    bus(1'b0, wbc_pkg::REG_STATUS, 32'h0);
    chk({rd[25:24], rd[12], rd[7:0], rd[11:8], rd[23:16]},
        {2'h0, 1'b1, st, key, asc}, "status");
  endtask : sts

  task good;
    sts(wbc_pkg::STAT_GOOD, wbc_pkg::KEY_NONE, wbc_pkg::ASC_NONE);
  endtask : good

  task rw(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
          input logic [23:0] off, input logic [23:0] len, input logic [7:0] asc);
    cmd(op, b1, b2, off, len, 3'h0);
    send(1);
    sts(wbc_pkg::STAT_CHECK, wbc_pkg::KEY_ILLEGAL, asc);
    chk(n_x, 0, "bytes after reject");
  endtask : rw

  task send(input int n);
    for (int k = 0; k < n; k++)
      bus(1'b1, wbc_pkg::REG_DATA, {24'h000000, 8'h10 + k[7:0]});
  endtask : send

  task word(input logic [3:0] i);
    bus(1'b1, wbc_pkg::REG_CTRL, {20'h00000, i, 8'h00});
    bus(1'b0, wbc_pkg::REG_DATA, 32'h0);
  endtask : word

  task t_mode;
    rw(8'h12, 8'h00, 8'h00, 24'h0, 24'h0, wbc_pkg::ASC_BAD_OP);
    for (int m = 0; m < 16; m++)
      if (!(m inside {2, 4, 5, 10}))
        rw(wbc_pkg::OP_WRBUF, 8'(m), 8'h00, 24'h0, 24'd16, wbc_pkg::ASC_FIELD);
  endtask : t_mode

  task t_data;
    logic [7:0] b1;
    b1 = {4'h0, wbc_pkg::MODE_DATA};
    rw(wbc_pkg::OP_WRBUF, b1, 8'h01, 24'h0, 24'd16, wbc_pkg::ASC_FIELD);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h41, 24'd16, wbc_pkg::ASC_FIELD);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd20, wbc_pkg::ASC_FIELD);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd64, wbc_pkg::ASC_FIELD);
    cmd(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h4, 24'd16, 3'h0);
    send(16);
    good();
    word(4'h1);
    chk(rd, 32'h13121110, "data at offset");
  endtask : t_data

  task t_dl;
    logic [7:0] b1;
    b1 = {4'h0, wbc_pkg::MODE_DL};
    bus(1'b1, wbc_pkg::REG_DLSIZE, 32'h8);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h01, 24'h0, 24'd8, wbc_pkg::ASC_FIELD);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h4, 24'd8, wbc_pkg::ASC_FIELD);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd4, wbc_pkg::ASC_FIELD);
    cmd(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'h0, 3'h0);
    good();
    chk(n_run + n_ua, 0, "zero length run");
    cmd(wbc_pkg::OP_WRBUF, b1, wbc_pkg::SEL_RSVD, 24'h0, 24'd8, 3'h3);
    send(8);
    good();
    chk(n_x, 8, "code bytes");
    chk(xfer_byte_o, 8'h17, "last code byte");
    chk(n_run, 1, "code run");
    chk(n_ua, 1, "attention");
    chk(ua_mask_o, 8'hf7, "attention mask");
    code_ok_i <= 1'b0;
    cmd(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd8, 3'h0);
    send(8);
    bus(1'b0, wbc_pkg::REG_STATUS, 32'h0);
    chk({rd[12], rd[7:0], rd[23:16]},
        {1'b1, wbc_pkg::STAT_CHECK, wbc_pkg::ASC_CODE}, "bad code");
    chk(n_run, 0, "bad code run");
    code_ok_i <= 1'b1;
  endtask : t_dl

  task t_save;
    logic [7:0] b1;
    b1 = {4'h0, wbc_pkg::MODE_SAVE};
    full_op_i <= 1'b0;
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd8, wbc_pkg::ASC_FIELD);
    full_op_i <= 1'b1;
    rw(wbc_pkg::OP_WRBUF, b1, wbc_pkg::SEL_RSVD, 24'h0, 24'd8, wbc_pkg::ASC_FIELD);
    rw(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd4, wbc_pkg::ASC_FIELD);
    cmd(wbc_pkg::OP_WRBUF, b1, 8'h00, 24'h0, 24'd8, 3'h0);
    send(8);
    good();
    chk(n_rst, 1, "self reset");
  endtask : t_save

  task t_echo;
    cmd(wbc_pkg::OP_WRBUF, {4'h0, wbc_pkg::MODE_ECHO}, 8'h00, 24'h0, 24'd8, 3'h0);
    send(8);
    good();
    word(4'h1);
    chk(rd, 32'h17161514, "echo word 1");
    word(4'h0);
    chk(rd, 32'h13121110, "echo word 0");
  endtask : t_echo

  task t_ext;
    int n;
    cmd(wbc_pkg::OP_WREXT, 8'h00, 8'h00, 24'h0, 24'h0, 3'h0);
    good();
    chk({n_seek[15:0], n_x[15:0]}, {16'd1, 16'd0}, "seek only");
    rw(wbc_pkg::OP_WREXT, 8'h01, 8'h00, 24'h0, 24'd1, wbc_pkg::ASC_FIELD);
    cmd(wbc_pkg::OP_WREXT, 8'h00, 8'h00, 24'h0, 24'd1, 3'h0);
    chk(cache_low_prio_o, 0, "normal priority");
    send(4);
    good();
    cmd(wbc_pkg::OP_WREXT, 8'h18, 8'h00, 24'h0, 24'd1, 3'h0);
    chk(cache_low_prio_o, 1, "low priority");
    send(4);
    bus(1'b0, wbc_pkg::REG_STATUS, 32'h0);
    chk({rd[25:24], rd[12], media_flush_o}, 4'h9, "media wait");
    n = 0;
    while (rd[12] !== 1'b1 && n < 40)
    begin
      bus(1'b0, wbc_pkg::REG_STATUS, 32'h0);
      n++;
    end
    good();
    chk(n_x, 4, "block bytes");
  endtask : t_ext

  initial
  begin
    rst_b_i         = 1'b0;
    avs_address_i   = 5'h00;
    avs_read_i      = 1'b0;
    avs_write_i     = 1'b0;
    avs_writedata_i = 32'h0;
    full_op_i       = 1'b1;
    code_ok_i       = 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    chk(ua_mask_o, 8'hfe, "reset mask");
    t_mode();
    t_data();
    t_dl();
    t_save();
    t_echo();
    t_ext();
    complete_run();
  end
endmodule : tb_top
